// ==== verilog/flash_host_pkg.sv ====
package flash_host_pkg;

  // flash bus geometry
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int BUF_DEPTH = 128;
  localparam int IDX_W = 7;
  localparam logic [7:0] BUF_LAST = 8'h7F;

  // apb register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_ACCEL_BIT = 8;
  localparam int CTRL_HWRST_BIT = 9;

  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ABORT_BIT = 2;
  localparam int ST_FAIL_BIT = 3;
  localparam int ST_SUSP_BIT = 4;
  localparam int ST_PARAM_BIT = 5;
  localparam int ST_BYPASS_BIT = 6;
  localparam int ST_RDATA_LSB = 16;

  // bits of a status read from the flash
  localparam int DATA_POLL_BIT = 7;
  localparam int TOGGLE_STATUS_BIT = 6;
  localparam int EXCEEDED_LIMIT_BIT = 5;
  localparam int BUFFER_ABORT_BIT = 1;

  // software operations written to the control register
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_BUF_PROG = 3'h1,
    OP_ABORT_RST = 3'h2,
    OP_RESET = 3'h3,
    OP_SUSPEND = 3'h4,
    OP_RESUME = 3'h5,
    OP_BYP_ENTER = 3'h6,
    OP_BYP_EXIT = 3'h7
  } op_type;

  // command cycles
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 23'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 23'h0002AA;
  localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_BUF_LOAD = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_BUF_CONFIRM = 16'h0029;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
  localparam logic [DATA_W-1:0] CMD_BYPASS = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_BYP_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_BYP_EXIT2 = 16'h0000;
  localparam logic [DATA_W-1:0] CMD_PROG_SUSP = 16'h0051;
  localparam logic [DATA_W-1:0] CMD_PROG_RES = 16'h0050;

  // bus cycle timing
  localparam int CLK_MHZ = 200;
  localparam int T_WE_LOW_NS = 35;
  localparam int T_RECOVER_NS = 20;
  localparam int T_ACCESS_NS = 70;
  localparam logic [4:0] WE_LOW_CYC = 5'((T_WE_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] RECOVER_CYC = 5'((T_RECOVER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] ACCESS_CYC = 5'((T_ACCESS_NS * CLK_MHZ + 999) / 1000);

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_cyc_type;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
  } flash_pins_type;

  localparam flash_pins_type PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 23'h000000, 16'h0000};
  localparam logic [31:0] CTRL_RST_VAL = 32'h00000000;

endpackage

// ==== verilog/flash_bus_cycle.sv ====
`timescale 1ns/10ps
module flash_bus_cycle (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // cycle request
  input wire logic req,
  input wire flash_host_pkg::bus_cyc_type cyc,
  output logic done,
  output logic [15:0] rdata,
  // flash pins
  input wire logic [15:0] dq_in,
  output flash_host_pkg::flash_pins_type pins
);
  import flash_host_pkg::*;

  typedef enum logic [1:0] {B_IDLE, B_STROBE, B_RECOVER, B_DONE} bus_state_type;

  bus_state_type state_ff, nxt_state;
  flash_pins_type pins_ff, nxt_pins;
  logic wr_ff, nxt_wr;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_state = state_ff;
    nxt_pins = pins_ff;
    nxt_wr = wr_ff;
    nxt_cnt = cnt_ff;
    nxt_rdata = rdata_ff;
    unique case (state_ff)
      B_IDLE: begin
        if (req) begin
          nxt_wr = cyc.wr;
          nxt_pins.addr = cyc.addr;
          nxt_pins.dq_out = cyc.data;
          nxt_pins.dq_oe_n = !cyc.wr;
          nxt_pins.ce_n = 1'b0;
          nxt_pins.we_n = !cyc.wr;
          nxt_pins.oe_n = cyc.wr;
          nxt_cnt = cyc.wr ? WE_LOW_CYC - 5'h01 : ACCESS_CYC - 5'h01;
          nxt_state = B_STROBE;
        end
      end
      B_STROBE: begin
        if (cnt_ff == 5'h00) begin
          if (!wr_ff) begin
            nxt_rdata = dq_in;
          end
          nxt_pins.ce_n = 1'b1;
          nxt_pins.we_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          nxt_cnt = RECOVER_CYC - 5'h01;
          nxt_state = B_RECOVER;
        end else begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      B_RECOVER: begin
        // data held past the rising strobe for hold time
        if (cnt_ff == 5'h00) begin
          nxt_pins.dq_oe_n = 1'b1;
          nxt_state = B_DONE;
        end else begin
          nxt_cnt = cnt_ff - 5'h01;
        end
      end
      B_DONE: nxt_state = B_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= B_IDLE;
      pins_ff <= PINS_IDLE;
      wr_ff <= 1'b0;
      cnt_ff <= 5'h00;
      rdata_ff <= 16'h0000;
    end else if (en) begin
      state_ff <= nxt_state;
      pins_ff <= nxt_pins;
      wr_ff <= nxt_wr;
      cnt_ff <= nxt_cnt;
      rdata_ff <= nxt_rdata;
    end
  end

  assign done = (state_ff == B_DONE);
  assign rdata = rdata_ff;
  assign pins = pins_ff;

  we_width_a: assert property (@(posedge clk) disable iff (rst)
    $fell(pins_ff.we_n) |-> !pins_ff.we_n [*7])
    else $error("write strobe shorter than its low time");

  we_drive_a: assert property (@(posedge clk) disable iff (rst)
    !pins_ff.we_n |-> (!pins_ff.dq_oe_n && !pins_ff.ce_n && pins_ff.oe_n))
    else $error("write strobe low without data driven");

endmodule

// ==== verilog/flash_buf_host.sv ====
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
// Function
// RULE_01: load at most 128 words per program
// RULE_02: two unlock cycles, then buffer-load command
// RULE_03: fourth cycle carries word count minus one
// RULE_04: count above buffer size aborts
// RULE_05: all loads stay in one 128-word page
// RULE_06: loads may come in any order
// RULE_07: out-of-page or other-sector write aborts
// RULE_08: counter decrements on every data load
// RULE_09: last load of a location wins
// RULE_10: confirm command at sector after loads
// RULE_11: poll status at last loaded address
// RULE_12: abort shows abort bit, inverted poll
// RULE_13: abort needs buffer-abort reset sequence
// RULE_14: failure needs reset; abort needs abort-reset
// RULE_15: reread poll bit after failure indication
// RULE_16: buffered program can suspend and resume
// RULE_17: no id or query access while programming
// RULE_18: same range may be reprogrammed without erase
// RULE_19: programming never turns zero to one
// RULE_20: high voltage pin enters unlock bypass
// RULE_21: abort reset in bypass uses three cycles
// RULE_22: unlock sectors before raising accel pin
// RULE_23: bypass entry is unlock pair plus 20h
// RULE_24: commands ignored while programming; reset terminates
module flash_buf_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins
  input wire logic [15:0] flash_dq_in,
  output flash_host_pkg::flash_pins_type flash_pins,
  output logic flash_rst_n,
  output logic protect_accel_pin_hv
);
  import flash_host_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE, ST_UNLK1, ST_UNLK2, ST_LOADCMD, ST_BYPCMD, ST_COUNT, ST_DATA, ST_CONFIRM,
    ST_POLL, ST_RECHECK, ST_SUSP, ST_HELD, ST_RESUME, ST_ARST1, ST_ARST2, ST_ARST3,
    ST_RESET, ST_BYPX1, ST_BYPX2
  } seq_state_type;

  // register group
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [7:0] count_ff, nxt_count;
  logic [7:0] wptr_ff, nxt_wptr;
  logic accel_ff, nxt_accel;
  logic hwrst_ff, nxt_hwrst;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [DATA_W-1:0] buf_ff [BUF_DEPTH];
  logic [DATA_W-1:0] nxt_buf [BUF_DEPTH];

  // sequencer group
  seq_state_type state_ff, nxt_state;
  op_type op_ff, nxt_op;
  logic [IDX_W-1:0] idx_ff, nxt_idx;
  logic done_ff, nxt_done;
  logic abort_ff, nxt_abort;
  logic fail_ff, nxt_fail;
  logic param_ff, nxt_param;
  logic susp_ff, nxt_susp;
  logic susp_req_ff, nxt_susp_req;
  logic saw_abort_ff, nxt_saw_abort;
  logic bypass_ff, nxt_bypass;

  logic wr_take, rd_setup, mapped, busy, go;
  op_type op_req;
  logic [31:0] status_word;
  logic [7:0] page_end;
  logic [ADDR_W-1:0] last_addr;
  logic exp_poll;
  bus_cyc_type cyc;
  logic cyc_req, cyc_done;
  logic [15:0] cyc_rdata;

  assign wr_take = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_COUNT) ||
                  (paddr == REG_DATA) || (paddr == REG_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign busy = (state_ff != ST_IDLE);
  assign go = wr_take && (paddr == REG_CTRL);
  assign op_req = op_type'(pwdata[CTRL_OP_LSB +: 3]);
  assign page_end = {1'b0, addr_ff[IDX_W-1:0]} + count_ff;
  assign last_addr = {addr_ff[ADDR_W-1:IDX_W], page_end[IDX_W-1:0]};
  // poll bit expected from the last loaded word, the one programmed there
  assign exp_poll = buf_ff[count_ff[IDX_W-1:0]][DATA_POLL_BIT]; // [RULE_09]

  always_comb begin
    status_word = 32'h00000000;
    status_word[ST_BUSY_BIT] = busy;
    status_word[ST_DONE_BIT] = done_ff;
    status_word[ST_ABORT_BIT] = abort_ff;
    status_word[ST_FAIL_BIT] = fail_ff;
    status_word[ST_SUSP_BIT] = susp_ff;
    status_word[ST_PARAM_BIT] = param_ff;
    status_word[ST_BYPASS_BIT] = bypass_ff;
    status_word[ST_RDATA_LSB +: 16] = cyc_rdata;
  end

  always_comb begin
    nxt_addr = addr_ff;
    nxt_count = count_ff;
    nxt_wptr = wptr_ff;
    nxt_accel = accel_ff;
    nxt_hwrst = hwrst_ff;
    nxt_prdata = prdata_ff;
    nxt_buf = buf_ff;
    if (wr_take) begin
      unique case (paddr)
        REG_CTRL: begin
          nxt_accel = pwdata[CTRL_ACCEL_BIT];
          nxt_hwrst = pwdata[CTRL_HWRST_BIT];
        end
        REG_ADDR: begin
          nxt_addr = pwdata[ADDR_W-1:0];
          nxt_wptr = 8'h00;
        end
        REG_COUNT: nxt_count = pwdata[7:0];
        REG_DATA: begin
          // buffer frozen while a program may still read it
          if (!busy && wptr_ff <= BUF_LAST) begin
            nxt_buf[wptr_ff[IDX_W-1:0]] = pwdata[DATA_W-1:0];
            nxt_wptr = wptr_ff + 8'h01;
          end
        end
        default: ;
      endcase
    end
    if (rd_setup) begin
      unique case (paddr)
        REG_CTRL: nxt_prdata = {22'h000000, hwrst_ff, accel_ff, 5'h00, op_ff};
        REG_ADDR: nxt_prdata = {9'h000, addr_ff};
        REG_COUNT: nxt_prdata = {24'h000000, count_ff};
        REG_DATA: nxt_prdata = {24'h000000, wptr_ff};
        REG_STATUS: nxt_prdata = status_word;
        default: nxt_prdata = 32'h00000000;
      endcase
    end
  end

  // command cycle for the current step
  always_comb begin
    cyc = '{wr: 1'b1, addr: addr_ff, data: 16'h0000};
    cyc_req = 1'b1;
    unique case (state_ff)
      ST_IDLE, ST_HELD: cyc_req = 1'b0;
      ST_UNLK1, ST_ARST1: cyc = '{1'b1, UNLOCK_A1, UNLOCK_D1}; // [RULE_02] [RULE_21]
      ST_UNLK2, ST_ARST2: cyc = '{1'b1, UNLOCK_A2, UNLOCK_D2};
      ST_ARST3: cyc = '{1'b1, UNLOCK_A1, CMD_RESET}; // [RULE_13]
      ST_BYPCMD: cyc = '{1'b1, UNLOCK_A1, CMD_BYPASS}; // [RULE_23]
      ST_LOADCMD: cyc.data = CMD_BUF_LOAD; // [RULE_02]
      ST_COUNT: cyc.data = {8'h00, count_ff}; // [RULE_03]
      ST_DATA: begin
        // loads walk the page in order; the device accepts any order
        cyc.addr = {addr_ff[ADDR_W-1:IDX_W], IDX_W'(addr_ff[IDX_W-1:0] + idx_ff)}; // [RULE_05]
        cyc.data = buf_ff[idx_ff]; // [RULE_06]
      end
      ST_CONFIRM: cyc.data = CMD_BUF_CONFIRM; // [RULE_10]
      ST_POLL, ST_RECHECK: cyc = '{1'b0, last_addr, 16'h0000}; // [RULE_11]
      ST_SUSP: cyc.data = CMD_PROG_SUSP; // [RULE_16]
      ST_RESUME: cyc.data = CMD_PROG_RES;
      ST_RESET: cyc.data = CMD_RESET; // [RULE_14]
      ST_BYPX1: cyc.data = CMD_BYP_EXIT1;
      ST_BYPX2: cyc.data = CMD_BYP_EXIT2;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_idx = idx_ff;
    nxt_done = done_ff;
    nxt_abort = abort_ff;
    nxt_fail = fail_ff;
    nxt_param = param_ff;
    nxt_susp = susp_ff;
    nxt_susp_req = susp_req_ff;
    nxt_saw_abort = saw_abort_ff;
    nxt_bypass = bypass_ff;
    // write-one-to-clear first, so a same-cycle set below wins
    if (wr_take && paddr == REG_STATUS) begin
      nxt_done = done_ff && !pwdata[ST_DONE_BIT];
      nxt_abort = abort_ff && !pwdata[ST_ABORT_BIT];
      nxt_fail = fail_ff && !pwdata[ST_FAIL_BIT];
      nxt_param = param_ff && !pwdata[ST_PARAM_BIT];
    end
    if (go && op_req == OP_SUSPEND && state_ff == ST_POLL) begin
      nxt_susp_req = 1'b1;
    end
    unique case (state_ff)
      ST_IDLE: begin
        // other operations are ignored unless idle, so nothing lands mid-program
        if (go) begin // [RULE_24] [RULE_17]
          nxt_op = op_req;
          nxt_idx = '0;
          unique case (op_req)
            OP_BUF_PROG: begin
              // never send a count the buffer or the page cannot hold
              if (count_ff > BUF_LAST || page_end > BUF_LAST) begin // [RULE_01] [RULE_04] [RULE_07]
                nxt_param = 1'b1;
              end else begin
                nxt_state = (bypass_ff || accel_ff) ? ST_LOADCMD : ST_UNLK1; // [RULE_20]
              end
            end
            OP_ABORT_RST: nxt_state = ST_ARST1;
            OP_RESET: nxt_state = ST_RESET;
            OP_BYP_ENTER: nxt_state = ST_UNLK1; // [RULE_23]
            OP_BYP_EXIT: nxt_state = ST_BYPX1;
            default: ;
          endcase
        end
      end
      ST_HELD: begin
        if (go && op_req == OP_RESUME) begin
          nxt_state = ST_RESUME; // [RULE_16]
        end
      end
      default: begin
        if (cyc_done) begin
          unique case (state_ff)
            ST_UNLK1: nxt_state = ST_UNLK2;
            ST_UNLK2: nxt_state = (op_ff == OP_BYP_ENTER) ? ST_BYPCMD : ST_LOADCMD;
            ST_BYPCMD: begin
              nxt_bypass = 1'b1;
              nxt_state = ST_IDLE;
            end
            ST_LOADCMD: nxt_state = ST_COUNT;
            ST_COUNT: nxt_state = ST_DATA;
            ST_DATA: begin
              // one load per counted location, the count value itself is the last index
              if ({1'b0, idx_ff} == count_ff) begin // [RULE_08]
                nxt_state = ST_CONFIRM;
              end else begin
                nxt_idx = idx_ff + 7'h01;
              end
            end
            ST_CONFIRM: nxt_state = ST_POLL;
            ST_POLL: begin
              if (cyc_rdata[DATA_POLL_BIT] == exp_poll) begin
                nxt_done = 1'b1; // [RULE_18] [RULE_19]
                nxt_state = ST_IDLE;
              end else if (cyc_rdata[EXCEEDED_LIMIT_BIT] || cyc_rdata[BUFFER_ABORT_BIT]) begin
                nxt_saw_abort = cyc_rdata[BUFFER_ABORT_BIT]; // [RULE_12]
                nxt_state = ST_RECHECK; // [RULE_15]
              end else if (susp_req_ff) begin
                nxt_susp_req = 1'b0;
                nxt_state = ST_SUSP;
              end
            end
            ST_RECHECK: begin
              if (cyc_rdata[DATA_POLL_BIT] == exp_poll) begin
                nxt_done = 1'b1;
                nxt_state = ST_IDLE;
              end else if (saw_abort_ff) begin
                nxt_abort = 1'b1;
                nxt_state = ST_ARST1; // [RULE_13] [RULE_14]
              end else begin
                nxt_fail = 1'b1;
                nxt_state = ST_RESET; // [RULE_14]
              end
            end
            ST_SUSP: begin
              nxt_susp = 1'b1;
              nxt_state = ST_HELD;
            end
            ST_RESUME: begin
              nxt_susp = 1'b0;
              nxt_state = ST_POLL;
            end
            ST_ARST1: nxt_state = ST_ARST2;
            ST_ARST2: nxt_state = ST_ARST3;
            ST_BYPX1: nxt_state = ST_BYPX2;
            ST_BYPX2: begin
              nxt_bypass = 1'b0;
              nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
          endcase
        end
      end
    endcase
    // hardware reset pin ends any operation and the bypass mode
    if (hwrst_ff) begin // [RULE_24]
      nxt_state = ST_IDLE;
      nxt_susp = 1'b0;
      nxt_susp_req = 1'b0;
      nxt_bypass = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_ff <= 23'h000000;
      count_ff <= 8'h00;
      wptr_ff <= 8'h00;
      accel_ff <= CTRL_RST_VAL[CTRL_ACCEL_BIT];
      hwrst_ff <= CTRL_RST_VAL[CTRL_HWRST_BIT];
      prdata_ff <= 32'h00000000;
      state_ff <= ST_IDLE;
      op_ff <= OP_NONE;
      idx_ff <= '0;
      done_ff <= 1'b0;
      abort_ff <= 1'b0;
      fail_ff <= 1'b0;
      param_ff <= 1'b0;
      susp_ff <= 1'b0;
      susp_req_ff <= 1'b0;
      saw_abort_ff <= 1'b0;
      bypass_ff <= 1'b0;
    end else if (en) begin
      addr_ff <= nxt_addr;
      count_ff <= nxt_count;
      wptr_ff <= nxt_wptr;
      accel_ff <= nxt_accel;
      hwrst_ff <= nxt_hwrst;
      prdata_ff <= nxt_prdata;
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      idx_ff <= nxt_idx;
      done_ff <= nxt_done;
      abort_ff <= nxt_abort;
      fail_ff <= nxt_fail;
      param_ff <= nxt_param;
      susp_ff <= nxt_susp;
      susp_req_ff <= nxt_susp_req;
      saw_abort_ff <= nxt_saw_abort;
      bypass_ff <= nxt_bypass;
    end
  end

  // buffer storage, no reset: words 0 to count are sent whether loaded or not
  always_ff @(posedge clk) begin
    if (en) begin
      buf_ff <= nxt_buf;
    end
  end

  flash_bus_cycle u_cycle (
    .clk(clk),
    .rst(rst || hwrst_ff),
    .en(en),
    .req(cyc_req && !hwrst_ff),
    .cyc(cyc),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .dq_in(flash_dq_in),
    .pins(flash_pins)
  );

  assign prdata = prdata_ff;
  assign flash_rst_n = !hwrst_ff;
  // software raises this only after the target sectors are unlocked
  assign protect_accel_pin_hv = accel_ff; // [RULE_22]

  sequence s_last_load;
    state_ff == ST_DATA && {1'b0, idx_ff} == count_ff && cyc_done && en && !hwrst_ff;
  endsequence

  sequence s_confirm_sent;
    state_ff == ST_CONFIRM && cyc.data == CMD_BUF_CONFIRM && cyc.addr == addr_ff;
  endsequence

  unlock_first_a: assert property (@(posedge clk) disable iff (rst) // [RULE_02]
    state_ff == ST_UNLK1 |-> cyc.addr == UNLOCK_A1 && cyc.data == UNLOCK_D1 && cyc_req)
    else $error("first unlock cycle wrong");

  count_cycle_a: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
    state_ff == ST_COUNT |-> cyc.data == {8'h00, count_ff} && cyc.addr == addr_ff)
    else $error("count cycle does not carry count");

  page_fixed_a: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
    state_ff == ST_DATA |-> cyc.addr[ADDR_W-1:IDX_W] == addr_ff[ADDR_W-1:IDX_W])
    else $error("load left the buffer page");

  confirm_after_a: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
    s_last_load |=> s_confirm_sent)
    else $error("confirm not sent after last load");

  poll_addr_a: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
    state_ff == ST_POLL |-> !cyc.wr && cyc.addr == last_addr)
    else $error("poll read not at last loaded address");

  recheck_a: assert property (@(posedge clk) disable iff (rst) // [RULE_15]
    (state_ff == ST_POLL && cyc_done && en && !hwrst_ff &&
     cyc_rdata[EXCEEDED_LIMIT_BIT] && cyc_rdata[DATA_POLL_BIT] != exp_poll)
    |=> state_ff == ST_RECHECK)
    else $error("limit bit not followed by reread");

  abort_recover_a: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
    $rose(abort_ff) |-> state_ff == ST_ARST1 || hwrst_ff)
    else $error("abort not followed by abort reset");

  fail_recover_a: assert property (@(posedge clk) disable iff (rst) // [RULE_14]
    $rose(fail_ff) |-> state_ff == ST_RESET || hwrst_ff)
    else $error("failure not followed by reset");

endmodule

// ==== verification/flash_dev_model.sv ====
`timescale 1ns/10ps
module flash_dev_model (
  // flash side
  input wire logic clk,
  input wire flash_host_pkg::flash_pins_type pins,
  input wire logic rst_n,
  input wire logic hv,
  input wire logic force_abort,
  output logic [15:0] dq
);
  import flash_host_pkg::*;
  logic [15:0] mem [int];
  logic [15:0] pend [int];
  logic [15:0] ld;
  logic [22:0] base, la;
  logic we_q, oe_q, byp, abt, fail, tog;
  int st, cnt, busy;
  initial begin
    {we_q, oe_q, byp, abt, fail, tog} = 6'b110000;
    st = 0;
    cnt = 0;
    busy = 0;
    ld = 16'h0000;
    dq = 16'h0000;
    base = '0;
    la = '0;
  end
  function automatic logic [15:0] rd(input int k);
    return mem.exists(k) ? mem[k] : 16'hFFFF;
  endfunction
  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    if (busy > 0) return;
    case (st)
      0: if (a == UNLOCK_A1 && d == UNLOCK_D1) st = 1;
        else if (d == CMD_RESET) fail = 0;
        else if (d == CMD_BYP_EXIT1) byp = 0;
        else if (d == CMD_BUF_LOAD && (byp || hv) && !abt) begin
          base = a;
          st = 3;
        end
      1: st = (a == UNLOCK_A2 && d == UNLOCK_D2) ? 2 : 0;
      2: begin
        st = 0;
        if (d == CMD_BUF_LOAD && !abt) begin
          base = a;
          st = 3;
        end
        if (d == CMD_BYPASS) byp = 1;
        if (d == CMD_RESET) abt = 0;
      end
      3: begin
        cnt = d;
        pend.delete();
        st = (d > 16'h007F) ? 0 : 4;
        abt = d > 16'h007F;
      end
      4: if (a[22:7] != base[22:7]) begin
          abt = 1;
          st = 0;
        end else begin
          pend[a] = d;
          la = a;
          ld = d;
          cnt--;
          if (cnt < 0) st = 5;
        end
      default: begin
        st = 0;
        if (d != CMD_BUF_CONFIRM || a[22:15] != base[22:15] || force_abort) abt = 1;
        else begin
          foreach (pend[k]) mem[k] = rd(k) & pend[k];
          busy = 40;
          fail = rd(la) != ld;
        end
      end
    endcase
  endtask
  always @(posedge clk) begin
    we_q <= pins.we_n;
    oe_q <= pins.oe_n;
    if (busy > 0) busy--;
    if (oe_q && !pins.oe_n) tog <= ~tog;
    if (!rst_n) begin
      st = 0;
      busy = 0;
      {abt, fail, byp} = 3'b000;
    end else if (!we_q && pins.we_n) wr(pins.addr, pins.dq_out);
    // released bus shows a moving pattern, never the last value
    if (!pins.ce_n && !pins.oe_n) dq <= (busy > 0 || abt || fail) ?
      {8'h00, ~ld[7], tog, fail, 3'b000, abt, 1'b0} : rd(pins.addr);
    else dq <= ~dq;
  end
endmodule

// ==== verification/flash_buf_host_tb.sv ====
`timescale 1ns/10ps
module flash_buf_host_tb;
  import flash_host_pkg::*;
  logic clk, rst, en, psel, penable, pwrite, pready, pslverr, frst_n, hv, fab, err, acc, sus;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [15:0] dq;
  flash_pins_type pins;
  logic [15:0] exp_mem [int];
  int n_fail, num_checks, cyc;
  flash_buf_host dut (.clk(clk), .rst(rst), .en(en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_dq_in(dq), .flash_pins(pins), .flash_rst_n(frst_n),
    .protect_accel_pin_hv(hv));
  flash_dev_model pm (.clk(clk), .pins(pins), .rst_n(frst_n), .hv(hv), .force_abort(fab),
    .dq(dq));
  always #2.5 clk = ~clk;
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // registered outputs settle after the taking edge
    @(negedge clk);
  endtask
  // n words from a, in order; ab means the caller has set the device to refuse the confirm
  task automatic prog(input logic [22:0] a, input int n, input logic ab);
    logic [15:0] d, old;
    logic fl;
    fl = 0;
    apb(1, REG_ADDR, 32'(a));
    apb(1, REG_COUNT, 32'(n - 1));
    for (int i = 0; i < n; i++) begin
      d = xs();
      old = exp_mem.exists(a + i) ? exp_mem[a + i] : 16'hFFFF;
      exp_mem[a + i] = ab ? old : old & d;
      fl = (old & d) != d;
      apb(1, REG_DATA, {16'h0000, d});
    end
    apb(1, REG_CTRL, {23'h0, acc, 5'h00, OP_BUF_PROG});
    // suspend only lands while polling, so keep asking until it is seen
    if (sus) begin
      do begin
        apb(1, REG_CTRL, 32'h4);
        apb(0, REG_STATUS, 32'h0);
      end while (r[ST_SUSP_BIT] !== 1'b1);
      chk(32'(r[4:0]), 32'h11);
      apb(1, REG_CTRL, 32'h5);
    end
    do apb(0, REG_STATUS, 32'h0); while (r[ST_BUSY_BIT] === 1'b1);
    chk(32'(r[5:0]), ab ? 32'h04 : fl ? 32'h08 : 32'h02);
    if (!ab && !fl) chk(32'(r[31:16]), 32'(exp_mem[a + n - 1]));
    for (int i = 0; i < n; i++) chk(32'(pm.rd(a + i)), 32'(exp_mem[a + i]));
    apb(1, REG_STATUS, 32'h2E);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    {clk, rst, en, psel, penable, pwrite, fab, acc, err, sus} = 10'b0110000000;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'd57605;
    {n_fail, num_checks, cyc} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(0, REG_STATUS, 32'h0);
    chk({r[30:0], frst_n}, 32'h1);
    apb(0, 8'h14, 32'h0);
    chk({r[30:0], err}, 32'h1);
    prog(23'h012345, 1, 0);
    prog(23'h012380, 128, 0);
    prog(23'h012380, 3, 0);
    for (int k = 0; k < 2; k++) begin
      apb(1, REG_ADDR, k ? 32'h7F : 32'h0);
      apb(1, REG_COUNT, k ? 32'h1 : 32'h80);
      apb(1, REG_CTRL, 32'h1);
      apb(0, REG_STATUS, 32'h0);
      chk(32'(r[5:0]), 32'h20);
      apb(1, REG_STATUS, 32'h2E);
    end
    fab <= 1'b1;
    prog(23'h020010, 3, 1);
    fab <= 1'b0;
    prog(23'h020010, 2, 0);
    acc = 1'b1;
    apb(1, REG_CTRL, 32'h100);
    chk(32'(hv), 32'h1);
    prog(23'h030000, 4, 0);
    acc = 1'b0;
    apb(1, REG_CTRL, 32'h200);
    chk(32'(frst_n), 32'h0);
    apb(1, REG_CTRL, 32'h0);
    chk(32'({hv, frst_n}), 32'h1);
    for (int k = 6; k < 8; k++) begin
      apb(1, REG_CTRL, 32'(k));
      do apb(0, REG_STATUS, 32'h0); while (r[ST_BUSY_BIT] === 1'b1);
      chk(32'(r[6:0]), k == 6 ? 32'h40 : 32'h00);
      if (k == 6) prog(23'h050000, 2, 0);
    end
    sus = 1'b1;
    prog(23'h040000, 1, 0);
    complete_run();
  end
endmodule
